// [verilog/sspp_pkg.sv]
// Purpose: Constants for the synthesizer serial programming port
// Assumes: 21-bit word, last two bits select one of three latches
// Notes: Latch field layouts beyond the control bits are held raw
// Function
// - A low chip enable powers the device down and floats the pump output.
// - A high chip enable powers up only if the power-down bit is clear.
// - Each rising serial clock edge shifts the data bit into a 21-bit word.
// - The last two bits shifted in select the destination latch.
// - A rising load strobe copies the word into the selected latch.
// - The monitor output shows RF divider, reference divider or lock.
// - Power-down comes from a programmed bit or the chip enable level.
// - A fast-settle mode drives its pin while powered up until a timeout counter expires.
// - A programmed selection can force the pump output to float.
package sspp_pkg;
  localparam int WORD_W = 21;
  localparam int CTRL_W = 2;
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_RF = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;
  localparam logic [20:0] LATCH_RST = 21'h00_0000;
  localparam int FUNC_PD_BIT = 2;
  localparam int FUNC_TRI_BIT = 3;
  localparam int FUNC_MON_LSB = 4;
  localparam int FUNC_FAST_BIT = 7;
  localparam int FUNC_TMO_LSB = 8;
  localparam int TMO_W = 4;
  localparam logic [1:0] MON_RF = 2'h0;
  localparam logic [1:0] MON_REF = 2'h1;
  localparam logic [1:0] MON_LOCK = 2'h2;
  localparam int TMO_SCALE = 4;
endpackage : sspp_pkg

// [verilog/sspp_top.sv]
// Purpose: Serial programming port and power control of a synthesizer
// Assumes: SER_CLK is the link clock; other pins are synchronised
// Notes: Init select loads the function latch as well
`timescale 1ns/10ps
module sspp_top (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic LATCH_LOAD_STROBE,
  input wire logic CHIP_EN,
  input wire logic RF_DIV_IN,
  input wire logic REF_DIV_IN,
  input wire logic LOCK_IN,
  output logic POWERED_UP,
  output logic PUMP_OUTPUT_OE,
  output logic DIVIDER_LOCK_MONITOR_OUTPUT,
  output logic FAST_SETTLE_OUTPUT,
  output logic [20:0] REF_LATCH,
  output logic [20:0] RF_LATCH,
  output logic [20:0] FUNC_LATCH
);
  logic [20:0] shift_q;
  logic [20:0] shift_d;
  logic tgl_q;
  logic [20:0] hold_q;
  logic [2:0] le_sync_q;
  logic [2:0] tgl_sync_q;
  logic [1:0] ce_sync_q;
  logic [1:0] rf_sync_q;
  logic [1:0] ref_sync_q;
  logic [1:0] lk_sync_q;
  logic [20:0] word_q;
  logic [9:0] fast_cnt_q;
  logic [9:0] fast_cnt_d;
  logic fast_busy_q;
  wire le_rise;
  wire new_word;
  wire [1:0] ctrl;
  wire pd_req;
  wire pwr_d;
  wire mon_d;
  wire fast_start;

  assign shift_d = {shift_q[19:0], SER_DATA};
  always_ff @(posedge SER_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      shift_q <= sspp_pkg::LATCH_RST;
    end else begin
      shift_q <= shift_d;
    end
  end

  // Snapshot and toggle on each rising serial clock edge for the crossing
  always_ff @(posedge SER_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      hold_q <= sspp_pkg::LATCH_RST;
      tgl_q <= 1'b0;
    end else begin
      hold_q <= shift_d;
      tgl_q <= ~tgl_q;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      le_sync_q <= 3'h0;
      tgl_sync_q <= 3'h0;
      ce_sync_q <= 2'h0;
      rf_sync_q <= 2'h0;
      ref_sync_q <= 2'h0;
      lk_sync_q <= 2'h0;
    end else begin
      le_sync_q <= {le_sync_q[1:0], LATCH_LOAD_STROBE};
      tgl_sync_q <= {tgl_sync_q[1:0], tgl_q};
      ce_sync_q <= {ce_sync_q[0], CHIP_EN};
      rf_sync_q <= {rf_sync_q[0], RF_DIV_IN};
      ref_sync_q <= {ref_sync_q[0], REF_DIV_IN};
      lk_sync_q <= {lk_sync_q[0], LOCK_IN};
    end
  end

  assign le_rise = le_sync_q[1] & ~le_sync_q[2];
  assign new_word = tgl_sync_q[1] ^ tgl_sync_q[2];

  // Word is stable once its toggle is seen; host idles clock before load
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      word_q <= sspp_pkg::LATCH_RST;
    end else if (new_word) begin
      word_q <= hold_q;
    end
  end

  assign ctrl = word_q[sspp_pkg::CTRL_W-1:0];

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      REF_LATCH <= sspp_pkg::LATCH_RST;
      RF_LATCH <= sspp_pkg::LATCH_RST;
      FUNC_LATCH <= sspp_pkg::LATCH_RST;
    end else if (le_rise) begin
      if (ctrl == sspp_pkg::SEL_REF) begin
        REF_LATCH <= word_q;
      end else if (ctrl == sspp_pkg::SEL_RF) begin
        RF_LATCH <= word_q;
      end else begin
        FUNC_LATCH <= word_q;
      end
    end
  end

  assign pd_req = FUNC_LATCH[sspp_pkg::FUNC_PD_BIT];
  assign pwr_d = ce_sync_q[1] & ~pd_req;

  assign mon_d =
    (FUNC_LATCH[sspp_pkg::FUNC_MON_LSB+:2] == sspp_pkg::MON_RF) ?
      rf_sync_q[1] :
    (FUNC_LATCH[sspp_pkg::FUNC_MON_LSB+:2] == sspp_pkg::MON_REF) ?
      ref_sync_q[1] :
    (FUNC_LATCH[sspp_pkg::FUNC_MON_LSB+:2] == sspp_pkg::MON_LOCK) ?
      lk_sync_q[1] : 1'b0;

  assign fast_start = le_rise & (ctrl != sspp_pkg::SEL_REF) &
    (ctrl != sspp_pkg::SEL_RF) & word_q[sspp_pkg::FUNC_FAST_BIT];
  assign fast_cnt_d = fast_start ?
    {word_q[sspp_pkg::FUNC_TMO_LSB+:sspp_pkg::TMO_W], 6'h00} :
    (fast_cnt_q != 10'h000) ? fast_cnt_q - 10'h001 : 10'h000;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      fast_cnt_q <= 10'h000;
      fast_busy_q <= 1'b0;
    end else begin
      fast_cnt_q <= fast_cnt_d;
      fast_busy_q <= fast_start | (fast_cnt_d != 10'h000);
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      POWERED_UP <= 1'b0;
      PUMP_OUTPUT_OE <= 1'b0;
      DIVIDER_LOCK_MONITOR_OUTPUT <= 1'b0;
      FAST_SETTLE_OUTPUT <= 1'b0;
    end else begin
      POWERED_UP <= pwr_d;
      PUMP_OUTPUT_OE <= pwr_d & ~FUNC_LATCH[sspp_pkg::FUNC_TRI_BIT];
      DIVIDER_LOCK_MONITOR_OUTPUT <= mon_d;
      FAST_SETTLE_OUTPUT <= fast_busy_q & pwr_d;
    end
  end

  a_ce_low_float: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !ce_sync_q[1] |=> !PUMP_OUTPUT_OE) else $error("pump driven while off");
  a_pd_bit_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    pd_req |=> !POWERED_UP) else $error("powered despite bit");
  a_ref_load: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    le_rise && ctrl == sspp_pkg::SEL_REF |=> REF_LATCH == $past(word_q))
    else $error("ref latch not loaded");
  a_latch_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !le_rise |=> $stable(RF_LATCH) && $stable(REF_LATCH))
    else $error("latch changed without load");
  a_tri_bit: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    FUNC_LATCH[sspp_pkg::FUNC_TRI_BIT] |=> !PUMP_OUTPUT_OE)
    else $error("pump driven in float mode");
  a_fast_start: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    fast_start ##1 pwr_d |=> FAST_SETTLE_OUTPUT)
    else $error("fast settle not started");
  a_power_up: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    ce_sync_q[1] && !pd_req |=> POWERED_UP) else $error("no power-up");
  a_shift_in: assert property (@(posedge SER_CLK) disable iff (SYS_RST)
    ##1 shift_q[0] == $past(SER_DATA)) else $error("bit not shifted");
endmodule : sspp_top

// [tb/sspp_host.sv]
// Purpose: Host model driving the serial programming pins
// Assumes: Serial clock stands still between words
// Notes: Idle data line shows the inverted last bit
`timescale 1ns/10ps
module sspp_host (
  output logic ser_clk,
  output logic ser_data
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
  end
  task automatic send(input logic [20:0] w);
    #7;
    for (int i = 20; i >= 0; i--) begin
      ser_data = w[i];
      #16 ser_clk = 1'b1;
      #16 ser_clk = 1'b0;
    end
    ser_data = ~w[0];
  endtask : send
endmodule : sspp_host

// [tb/sspp_top_bench.sv]
// Purpose: Self-checking bench for the serial programming port
// Assumes: Latches and outputs settle within 6 system cycles
// Notes: Fast-settle length is timeout times 64 cycles
`timescale 1ns/10ps
module sspp_top_bench;
  logic CLK_SYS, SYS_RST, LATCH_LOAD_STROBE, CHIP_EN, RF_DIV_IN;
  logic REF_DIV_IN, LOCK_IN, POWERED_UP, PUMP_OUTPUT_OE, FAST_SETTLE_OUTPUT;
  logic DIVIDER_LOCK_MONITOR_OUTPUT, SER_CLK, SER_DATA;
  logic [20:0] REF_LATCH, RF_LATCH, FUNC_LATCH, e_ref, e_rf, e_func, w;
  int n_mismatch, checked;
  sspp_top u_dut (.*);
  sspp_host u_host (.ser_clk(SER_CLK), .ser_data(SER_DATA));
  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end
  task automatic cmp(input logic [20:0] seen, input logic [20:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : cmp
  task automatic give_verdict;
    $display("Counts: %0d checked, %0d mismatched", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  function automatic logic mon_exp(input logic [1:0] s);
    case (s)
      2'h0: return RF_DIV_IN;
      2'h1: return REF_DIV_IN;
      2'h2: return LOCK_IN;
      default: return 1'b0;
    endcase
  endfunction : mon_exp
  task automatic load(input logic [20:0] x);
    u_host.send(x);
    repeat (5) @(negedge CLK_SYS);
    LATCH_LOAD_STROBE = 1'b1;
    repeat (6) @(negedge CLK_SYS);
    LATCH_LOAD_STROBE = 1'b0;
    if (x[1:0] == 2'h0) e_ref = x;
    else if (x[1:0] == 2'h1) e_rf = x;
    else e_func = x;
  endtask : load
  task automatic chk_latches;
    cmp(REF_LATCH, e_ref);
    cmp(RF_LATCH, e_rf);
    cmp(FUNC_LATCH, e_func);
  endtask : chk_latches
  initial begin
    {SYS_RST, LATCH_LOAD_STROBE, CHIP_EN, RF_DIV_IN, REF_DIV_IN} = 5'h10;
    LOCK_IN = 1'b0;
    {e_ref, e_rf, e_func} = '0;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(32'h7f8f));
    repeat (2) @(negedge CLK_SYS);
    SYS_RST = 1'b0;
    CHIP_EN = 1'b1;
    repeat (2) @(negedge CLK_SYS);
    chk_latches();
    for (int i = 0; i < 12; i++) begin
      u_host.send($urandom);
      w = $urandom;
      w[1:0] = i[1:0];
      load(w);
      chk_latches();
    end
    $display("Test random loads done");
    u_host.send($urandom);
    repeat (8) @(negedge CLK_SYS);
    chk_latches();
    $display("Test shift only done");
    for (int i = 0; i < 8; i++) begin
      CHIP_EN = i[2];
      load({17'h0, i[1], i[0], 2'h2});
      repeat (6) @(negedge CLK_SYS);
      w = {19'h0, i[2] & ~i[0], i[2] & ~i[0] & ~i[1]};
      cmp({19'h0, POWERED_UP, PUMP_OUTPUT_OE}, w);
    end
    $display("Test power done");
    CHIP_EN = 1'b1;
    for (int m = 0; m < 4; m++) begin
      load({15'h0, m[1:0], 4'h2});
      for (int k = 0; k < 4; k++) begin
        {RF_DIV_IN, REF_DIV_IN, LOCK_IN} = 3'($urandom);
        repeat (6) @(negedge CLK_SYS);
        cmp({20'h0, DIVIDER_LOCK_MONITOR_OUTPUT}, {20'h0, mon_exp(m[1:0])});
      end
    end
    $display("Test monitor done");
    load({9'h0, 4'h1, 1'b1, 7'h2});
    cmp({20'h0, FAST_SETTLE_OUTPUT}, 21'h1);
    repeat (80) @(negedge CLK_SYS);
    cmp({20'h0, FAST_SETTLE_OUTPUT}, 21'h0);
    $display("Test fast settle done");
    give_verdict();
  end
  initial begin
    #2000000;
    n_mismatch++;
    give_verdict();
  end
endmodule : sspp_top_bench
